// ---- logic/cdcc_core.v ----
// Charge and discharge counting core with register map and calibration.
//
// Function
// - Discharge sense drives discharge accumulator and discharge time counter at documented rates.
// - Charge sense drives charge accumulator and charge time counter at documented rates.
// - Time counters wrap past ffffh, toggle rollover flag, and advance 256 times slower while it is set.
// - Above threshold with line high, counters run, wake drives low, registers accessible.
// - Below threshold with line low over ten seconds suspends counting until line high.
// - Self-leak counter runs once per hour at 25C, doubling per 10C step.
// - Temperature reads as 3-bit code; code 3 is base rate, scaled x1/8 to x16.
// - Offset register holds 8-bit two's complement offset in accumulator units.
// - Below threshold the wake pin floats until current rises above threshold.
// - Mode and threshold register resets to 0eh, threshold code 7.
// - Threshold is 3.84mV divided by field value; zero means no threshold.
// - Writing 1 to a clear bit zeroes the matching counter and leaves the other four alone.
// - Clear bits return to zero by themselves once the clear is done.
// - Clearing a time counter also clears its rollover flag and slow rate.
// - Calibration bit armed; calibration starts after ten seconds line low below threshold.
// - One hour qualifying latches measured offset and clears calibration bit.
// - Top thirteen addresses are registers (73h to 75h) and counters (76h to 7fh); addresses 72h down to 00h are user memory.
// - Command byte bit 7 selects write or read, bits 6 to 0 address.
// - Override bit drops line-low need during calibration; cleared at valid calibration end.
// - Sense above threshold, or line high without override, restarts calibration, calibration bit kept.
`include "cdcc_consts.vh"
`default_nettype none

module cdcc_core #(
  parameter integer TICK_CYCLES = `CDCC_TICK_CYCLES,
  parameter integer LOW_WAIT_CYCLES = `CDCC_LOW_WAIT_CYCLES
) (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire signed [17:0] sense_input_battery_side,
  input wire signed [17:0] sense_input_pack_side,
  input wire signed [17:0] input_offset_voltage,
  input wire [2:0] temp_sensor_code,
  input wire single_wire_line,
  input wire cmd_byte_valid,
  input wire [7:0] cmd_byte_data,
  output reg reply_valid,
  output reg [7:0] reply_data,
  output reg wake_out,
  output reg wake_oe,
  output reg asleep,
  output reg cal_active
);

  localparam [25:0] TICK_LAST = TICK_CYCLES[25:0] - 26'h0000001;
  localparam [28:0] LOW_LAST = LOW_WAIT_CYCLES[28:0] - 29'h00000001;
  localparam [7:0] MODE_RESET = `CDCC_MODE_RESET;

  // ========================================================================
  // Functions
  function [18:0] cdcc_mag;
    input signed [18:0] v;
    begin
      cdcc_mag = v[18] ? (~v + 19'h00001) : v;
    end
  endfunction

  // Threshold in microvolts for each field code.
  function [18:0] cdcc_thr;
    input [2:0] code;
    begin
      case (code)
        3'h1: cdcc_thr = `CDCC_FULL_THR_UV;
        3'h2: cdcc_thr = 19'h00780;
        3'h3: cdcc_thr = 19'h00500;
        3'h4: cdcc_thr = 19'h003c0;
        3'h5: cdcc_thr = 19'h00300;
        3'h6: cdcc_thr = 19'h00280;
        3'h7: cdcc_thr = 19'h00225;
        default: cdcc_thr = 19'h00000;
      endcase
    end
  endfunction

  function [7:0] cdcc_pick;
    input [15:0] word;
    input hi;
    begin
      cdcc_pick = hi ? word[15:8] : word[7:0];
    end
  endfunction

  // ========================================================================
  // Registers and state
  reg [25:0] tick_cnt;
  reg tick;
  reg [28:0] low_cnt;
  reg [11:0] hour_cnt;
  reg [7:0] offset_trim_value;
  reg [2:0] temp_code;
  reg [4:0] clr_pend;
  reg line_low_override;
  reg cal_bit;
  reg charge_time_rollover_flag;
  reg discharge_time_rollover_flag;
  reg [2:0] wake_threshold_field;
  reg [15:0] charge_time_counter;
  reg [15:0] discharge_time_counter;
  reg [7:0] chg_slow;
  reg [7:0] dis_slow;
  reg wr_pending;
  reg [6:0] wr_addr;
  reg [7:0] user_mem [0:114];

  wire [15:0] charge_accumulator;
  wire [15:0] discharge_accumulator;
  wire [15:0] self_leak_counter;

  // ========================================================================
  // Sense evaluation
  wire signed [18:0] sense_total = sense_input_battery_side - sense_input_pack_side
    + input_offset_voltage;
  wire [18:0] sense_mag = cdcc_mag(sense_total);
  wire [18:0] wake_threshold_voltage = cdcc_thr(wake_threshold_field);
  wire above = sense_mag > wake_threshold_voltage;
  wire below = ~above;
  wire charging = (sense_total > 19'sd0);
  wire discharging = sense_total[18];
  wire run = ~asleep;
  wire run_tick = tick & run;
  wire [20:0] sense_add = {1'b0, sense_mag, 1'b0};
  wire [20:0] leak_add = {13'h0000, 8'h01 << temp_code};

  wire line_low_qual = ~single_wire_line & below;
  wire low_done = line_low_qual & (low_cnt == LOW_LAST);
  wire cal_ok = below & (~single_wire_line | line_low_override);

  // Command and data decoding.
  wire is_cmd = cmd_byte_valid & ~wr_pending;
  wire is_data = cmd_byte_valid & wr_pending;
  wire mode_wr = is_data & (wr_addr == `CDCC_ADDR_MODE);
  wire clr_wr = is_data & (wr_addr == `CDCC_ADDR_TMPCLR);
  wire [4:0] clr_set = clr_wr ? cmd_byte_data[4:0] : 5'h00;

  // ========================================================================
  // Timebase
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt <= 26'h0000000;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? 26'h0000000 : tick_cnt + 26'h0000001;
    end
  end

  // ========================================================================
  // Accumulators
  cdcc_rate_acc u_chg_acc (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce & run),
    .clr(clr_pend[`CDCC_CLR_CHG_BIT]),
    .tick(run_tick & charging),
    .add(sense_add),
    .limit(`CDCC_ACC_LIMIT),
    .count(charge_accumulator)
  );

  cdcc_rate_acc u_dis_acc (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce & run),
    .clr(clr_pend[`CDCC_CLR_DIS_BIT]),
    .tick(run_tick & discharging),
    .add(sense_add),
    .limit(`CDCC_ACC_LIMIT),
    .count(discharge_accumulator)
  );

  // Weight 2^code against a limit of 8 hours of ticks gives 1/8 to 16 per hour.
  cdcc_rate_acc u_leak_acc (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce & run),
    .clr(clr_pend[`CDCC_CLR_SLC_BIT]),
    .tick(run_tick),
    .add(leak_add),
    .limit(`CDCC_LEAK_LIMIT),
    .count(self_leak_counter)
  );

  // ========================================================================
  // Time counters
  // A second wrap toggles the rollover flag back to zero.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      charge_time_counter <= 16'h0000;
      discharge_time_counter <= 16'h0000;
      chg_slow <= 8'h00;
      dis_slow <= 8'h00;
      charge_time_rollover_flag <= 1'b0;
      discharge_time_rollover_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (clr_pend[`CDCC_CLR_CTC_BIT])
      begin
        charge_time_counter <= 16'h0000;
        chg_slow <= 8'h00;
        charge_time_rollover_flag <= 1'b0;
      end
      else if (run_tick & charging)
      begin
        chg_slow <= chg_slow + 8'h01;
        if (!charge_time_rollover_flag || chg_slow == `CDCC_SLOW_DIV_LAST)
        begin
          charge_time_counter <= charge_time_counter + 16'h0001;
          if (charge_time_counter == 16'hffff)
            charge_time_rollover_flag <= ~charge_time_rollover_flag;
        end
      end
      if (clr_pend[`CDCC_CLR_DTC_BIT])
      begin
        discharge_time_counter <= 16'h0000;
        dis_slow <= 8'h00;
        discharge_time_rollover_flag <= 1'b0;
      end
      else if (run_tick & discharging)
      begin
        dis_slow <= dis_slow + 8'h01;
        if (!discharge_time_rollover_flag || dis_slow == `CDCC_SLOW_DIV_LAST)
        begin
          discharge_time_counter <= discharge_time_counter + 16'h0001;
          if (discharge_time_counter == 16'hffff)
            discharge_time_rollover_flag <= ~discharge_time_rollover_flag;
        end
      end
    end
  end

  // ========================================================================
  // Sleep, wake and clear handling
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_cnt <= 29'h00000000;
      asleep <= 1'b0;
      wake_out <= 1'b0;
      wake_oe <= 1'b0;
      temp_code <= 3'h3;
      clr_pend <= 5'h00;
    end
    else if (ce)
    begin
      if (!line_low_qual)
        low_cnt <= 29'h00000000;
      else if (low_cnt != LOW_LAST)
        low_cnt <= low_cnt + 29'h00000001;
      if (single_wire_line)
        asleep <= 1'b0;
      else if (low_done)
        asleep <= 1'b1;
      wake_out <= 1'b0;
      wake_oe <= above;
      temp_code <= temp_sensor_code;
      clr_pend <= clr_set;
    end
  end

  // ========================================================================
  // Mode register and calibration
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line_low_override <= MODE_RESET[`CDCC_MODE_OVR_BIT];
      cal_bit <= MODE_RESET[`CDCC_MODE_CAL_BIT];
      wake_threshold_field <= MODE_RESET[3:1];
      cal_active <= 1'b0;
      hour_cnt <= 12'h000;
      offset_trim_value <= 8'h00;
    end
    else if (ce)
    begin
      if (!cal_bit || !cal_ok)
      begin
        cal_active <= 1'b0;
        hour_cnt <= 12'h000;
      end
      else if (!cal_active)
      begin
        if (line_low_override || low_done)
          cal_active <= 1'b1;
      end
      else if (tick)
      begin
        hour_cnt <= hour_cnt + 12'h001;
        if (hour_cnt == `CDCC_TICKS_PER_HOUR)
        begin
          offset_trim_value <= cdcc_trim(input_offset_voltage);
          cal_bit <= 1'b0;
          line_low_override <= 1'b0;
          cal_active <= 1'b0;
        end
      end
      if (mode_wr)
      begin
        line_low_override <= cmd_byte_data[`CDCC_MODE_OVR_BIT];
        cal_bit <= cmd_byte_data[`CDCC_MODE_CAL_BIT];
        wake_threshold_field <= cmd_byte_data[3:1];
      end
      if (is_data && wr_addr == `CDCC_ADDR_OFFSET)
        offset_trim_value <= cmd_byte_data;
    end
  end

  function [7:0] cdcc_trim;
    input signed [17:0] vos;
    reg signed [18:0] scaled;
    begin
      scaled = (vos * 19'sd2) / `CDCC_UV_PER_TRIM;
      cdcc_trim = scaled[7:0];
    end
  endfunction

  // ========================================================================
  // Command port and register map
  wire [7:0] mode_image = {line_low_override, cal_bit, charge_time_rollover_flag,
    discharge_time_rollover_flag, wake_threshold_field, 1'b0};

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pending <= 1'b0;
      wr_addr <= 7'h00;
      reply_valid <= 1'b0;
      reply_data <= 8'h00;
    end
    else if (ce)
    begin
      reply_valid <= 1'b0;
      if (is_data)
        wr_pending <= 1'b0;
      else if (is_cmd)
      begin
        wr_addr <= cmd_byte_data[6:0];
        if (cmd_byte_data[`CDCC_CMD_WRITE_BIT])
          wr_pending <= 1'b1;
        else
        begin
          reply_valid <= 1'b1;
          case (cmd_byte_data[6:0])
            `CDCC_ADDR_OFFSET: reply_data <= offset_trim_value;
            `CDCC_ADDR_TMPCLR: reply_data <= {temp_code, clr_pend};
            `CDCC_ADDR_MODE: reply_data <= mode_image;
            `CDCC_ADDR_CTC_LO: reply_data <= cdcc_pick(charge_time_counter, 1'b0);
            `CDCC_ADDR_CTC_HI: reply_data <= cdcc_pick(charge_time_counter, 1'b1);
            `CDCC_ADDR_DTC_LO: reply_data <= cdcc_pick(discharge_time_counter, 1'b0);
            `CDCC_ADDR_DTC_HI: reply_data <= cdcc_pick(discharge_time_counter, 1'b1);
            `CDCC_ADDR_SLC_LO: reply_data <= cdcc_pick(self_leak_counter, 1'b0);
            `CDCC_ADDR_SLC_HI: reply_data <= cdcc_pick(self_leak_counter, 1'b1);
            `CDCC_ADDR_CHG_LO: reply_data <= cdcc_pick(charge_accumulator, 1'b0);
            `CDCC_ADDR_CHG_HI: reply_data <= cdcc_pick(charge_accumulator, 1'b1);
            `CDCC_ADDR_DIS_LO: reply_data <= cdcc_pick(discharge_accumulator, 1'b0);
            `CDCC_ADDR_DIS_HI: reply_data <= cdcc_pick(discharge_accumulator, 1'b1);
            default: reply_data <= user_mem[cmd_byte_data[6:0]];
          endcase
        end
      end
    end
  end

  // User memory has no reset; it keeps whatever software left there.
  always @(posedge mclk)
  begin
    if (ce && is_data && wr_addr <= `CDCC_ADDR_USER_LAST)
      user_mem[wr_addr] <= cmd_byte_data;
  end

endmodule // cdcc_core

`default_nettype wire

// ---- logic/cdcc_consts.vh ----
// Constants for the charge and discharge counting core.
`ifndef CDCC_CONSTS_VH
`define CDCC_CONSTS_VH

// ==========================================================================
// Clock and timing
`define CDCC_CLK_PERIOD_NS 25
`define CDCC_CLK_KHZ 40000
`define CDCC_TICK_NS 878906250
`define CDCC_TICK_CYCLES (`CDCC_TICK_NS / `CDCC_CLK_PERIOD_NS)
`define CDCC_LOW_WAIT_MS 10000
`define CDCC_LOW_WAIT_CYCLES (`CDCC_LOW_WAIT_MS * `CDCC_CLK_KHZ)
`define CDCC_TICKS_PER_HOUR 12'hfff
`define CDCC_SLOW_DIV_LAST 8'hff

// ==========================================================================
// Accumulation limits in half-microvolt tick sums and leak weights; threshold in microvolts, trim scale in half-microvolts
`define CDCC_ACC_LIMIT 21'h019000
`define CDCC_LEAK_LIMIT 21'h008000
`define CDCC_FULL_THR_UV 19'h00f00
`define CDCC_UV_PER_TRIM 19'sd25

// ==========================================================================
// Register offsets
`define CDCC_ADDR_USER_LAST 7'h72
`define CDCC_ADDR_OFFSET 7'h73
`define CDCC_ADDR_TMPCLR 7'h74
`define CDCC_ADDR_MODE 7'h75
`define CDCC_ADDR_CTC_LO 7'h76
`define CDCC_ADDR_CTC_HI 7'h77
`define CDCC_ADDR_DTC_LO 7'h78
`define CDCC_ADDR_DTC_HI 7'h79
`define CDCC_ADDR_SLC_LO 7'h7a
`define CDCC_ADDR_SLC_HI 7'h7b
`define CDCC_ADDR_CHG_LO 7'h7c
`define CDCC_ADDR_CHG_HI 7'h7d
`define CDCC_ADDR_DIS_LO 7'h7e
`define CDCC_ADDR_DIS_HI 7'h7f

// ==========================================================================
// Field positions and reset values
`define CDCC_CMD_WRITE_BIT 7
`define CDCC_MODE_OVR_BIT 7
`define CDCC_MODE_CAL_BIT 6
`define CDCC_MODE_STC_BIT 5
`define CDCC_MODE_STD_BIT 4
`define CDCC_MODE_RESET 8'h0e
`define CDCC_CLR_CTC_BIT 4
`define CDCC_CLR_DTC_BIT 3
`define CDCC_CLR_SLC_BIT 2
`define CDCC_CLR_CHG_BIT 1
`define CDCC_CLR_DIS_BIT 0

`endif

// ---- logic/cdcc_rate_acc.v ----
// Fractional rate accumulator that turns tick-weighted sums into counts.
`include "cdcc_consts.vh"
`default_nettype none

module cdcc_rate_acc (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire clr,
  input wire tick,
  input wire [20:0] add,
  input wire [20:0] limit,
  output reg [15:0] count
);

  reg [21:0] frac;

  // ========================================================================
  // Accumulate
  // A sum may hold several counts; one is drained per clock, far faster
  // than the tick spacing, so nothing is lost between ticks.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frac <= 22'h000000;
      count <= 16'h0000;
    end
    else if (ce)
    begin
      if (clr)
      begin
        frac <= 22'h000000;
        count <= 16'h0000;
      end
      else if (frac >= {1'b0, limit})
      begin
        frac <= frac - {1'b0, limit} + (tick ? {1'b0, add} : 22'h000000);
        count <= count + 16'h0001;
      end
      else if (tick)
      begin
        frac <= frac + {1'b0, add};
      end
    end
  end

endmodule // cdcc_rate_acc

`default_nettype wire

// ---- bench/cdcc_core_asserts.sv ----
// Port-level assertions for the charge and discharge counting core.
`default_nettype none

module cdcc_core_asserts #(
  parameter integer LOW_WAIT_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic signed [17:0] sense_input_battery_side,
  input wire logic signed [17:0] sense_input_pack_side,
  input wire logic signed [17:0] input_offset_voltage,
  input wire logic [2:0] temp_sensor_code,
  input wire logic single_wire_line,
  input wire logic cmd_byte_valid,
  input wire logic [7:0] cmd_byte_data,
  input wire logic reply_valid,
  input wire logic [7:0] reply_data,
  input wire logic wake_out,
  input wire logic wake_oe,
  input wire logic asleep,
  input wire logic cal_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Shadow of the command decoder and of the wake threshold
  logic pend;
  logic pend_mode;
  logic [2:0] thr_code;
  int lowrun;
  wire take = ce && cmd_byte_valid;
  wire rd_take = take && !pend && !cmd_byte_data[7];
  wire signed [19:0] vsum = sense_input_battery_side - sense_input_pack_side
    + input_offset_voltage;
  wire [19:0] vmag = vsum[19] ? -vsum : vsum;
  wire [19:0] thr_uv = (thr_code == 3'h0) ? 20'h0 : (thr_code == 3'h7) ? 20'h00225
    : 20'h00f00 / thr_code;
  wire over = vmag > thr_uv;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend <= 1'b0;
      pend_mode <= 1'b0;
      thr_code <= 3'h7;
      lowrun <= 0;
    end
    else if (ce)
    begin
      lowrun <= (!single_wire_line && !over) ? lowrun + 1 : 0;
      if (cmd_byte_valid)
      begin
        pend <= !pend && cmd_byte_data[7];
        pend_mode <= !pend && cmd_byte_data == 8'hf5;
        if (pend_mode)
          thr_code <= cmd_byte_data[3:1];
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_read_answer: assert property (rd_take |=> reply_valid)
    else $error("read command got no answer");
  a_write_silent: assert property (take && !rd_take |=> !reply_valid)
    else $error("write byte produced an answer");
  a_reply_cause: assert property (reply_valid |-> $past(rd_take))
    else $error("answer without a read command");
  a_reply_holds: assert property (!reply_valid |-> $stable(reply_data))
    else $error("answer data changed without a read");
  a_wake_low: assert property (!wake_out)
    else $error("wake pin data not low");
  a_wake_threshold: assert property (ce |=> wake_oe == $past(over))
    else $error("wake enable disagrees with threshold");
  a_sleep_exit: assert property (asleep && single_wire_line && ce |=> !asleep)
    else $error("sleep kept with line high");
  a_sleep_entry: assert property ($rose(asleep) |-> lowrun >= LOW_WAIT_CYCLES - 1)
    else $error("sleep entered before the low wait ran out");
  a_cal_break: assert property (cal_active && over |-> ##[1:2] !cal_active)
    else $error("calibration kept with signal above threshold");
endmodule // cdcc_core_asserts

bind cdcc_core cdcc_core_asserts #(.LOW_WAIT_CYCLES(LOW_WAIT_CYCLES)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .ce(ce),
  .sense_input_battery_side(sense_input_battery_side),
  .sense_input_pack_side(sense_input_pack_side),
  .input_offset_voltage(input_offset_voltage), .temp_sensor_code(temp_sensor_code),
  .single_wire_line(single_wire_line), .cmd_byte_valid(cmd_byte_valid),
  .cmd_byte_data(cmd_byte_data), .reply_valid(reply_valid), .reply_data(reply_data),
  .wake_out(wake_out), .wake_oe(wake_oe), .asleep(asleep), .cal_active(cal_active)
);

`default_nettype wire

// ---- bench/cdcc_host.sv ----
// Host controller model that sends command and data bytes to the counting core.
`default_nettype none

module cdcc_host (
  input wire logic mclk,
  input wire logic reply_valid,
  input wire logic [7:0] reply_data,
  output logic cmd_byte_valid,
  output logic [7:0] cmd_byte_data,
  output logic single_wire_line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cmd_byte_valid = 1'b0;
    cmd_byte_data = 8'h00;
    single_wire_line = 1'b1;
  end

  // ==========================================================================
  // Byte transfers
  task automatic put(input logic [7:0] b);
    @(posedge mclk);
    #1;
    cmd_byte_valid = 1'b1;
    cmd_byte_data = b;
  endtask

  // A released byte bus shows the inverse of the last byte.
  task automatic drop;
    @(posedge mclk);
    #1;
    cmd_byte_valid = 1'b0;
    cmd_byte_data = ~cmd_byte_data;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    put({1'b1, a});
    put((a == 7'h75) ? (d & 8'hfe) : d);
    drop;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic got);
    put({1'b0, a});
    drop;
    got = reply_valid;
    d = reply_data;
  endtask

  task automatic line(input logic v);
    @(posedge mclk);
    #1;
    single_wire_line = v;
  endtask
endmodule // cdcc_host

`default_nettype wire

// ---- bench/cdcc_core_test.sv ----
// Self-checking bench for the charge and discharge counting core.
`default_nettype none
`include "cdcc_consts.vh"

module cdcc_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 20;
  localparam int LOWW = 50;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic signed [17:0] sense_input_battery_side = 18'h00000;
  logic signed [17:0] sense_input_pack_side = 18'h00000;
  logic signed [17:0] input_offset_voltage = 18'h00000;
  logic [2:0] temp_sensor_code = 3'h3;
  logic single_wire_line;
  logic cmd_byte_valid;
  logic [7:0] cmd_byte_data;
  logic reply_valid;
  logic [7:0] reply_data;
  logic wake_out;
  logic wake_oe;
  logic asleep;
  logic cal_active;
  int mismatches = 0;
  int n_compared = 0;

  always #12.5 mclk = ~mclk;

  cdcc_core #(.TICK_CYCLES(TICK), .LOW_WAIT_CYCLES(LOWW)) uut (
    .mclk(mclk), .rst_b(rst_b), .ce(ce),
    .sense_input_battery_side(sense_input_battery_side),
    .sense_input_pack_side(sense_input_pack_side),
    .input_offset_voltage(input_offset_voltage), .temp_sensor_code(temp_sensor_code),
    .single_wire_line(single_wire_line), .cmd_byte_valid(cmd_byte_valid),
    .cmd_byte_data(cmd_byte_data), .reply_valid(reply_valid), .reply_data(reply_data),
    .wake_out(wake_out), .wake_oe(wake_oe), .asleep(asleep), .cal_active(cal_active)
  );

  cdcc_host host (
    .mclk(mclk), .reply_valid(reply_valid), .reply_data(reply_data),
    .cmd_byte_valid(cmd_byte_valid), .cmd_byte_data(cmd_byte_data),
    .single_wire_line(single_wire_line)
  );

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic g;
    host.rd(a, d, g);
    check({15'h0, g}, 16'h0001);
    check({8'h00, d}, {8'h00, exp});
  endtask

  task automatic rd16(input logic [6:0] a, output logic [15:0] v);
    logic g;
    host.rd(a, v[7:0], g);
    host.rd(a + 7'h01, v[15:8], g);
  endtask

  task automatic rd16c(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd16(a, v);
    check(v, exp);
  endtask

  task automatic drive(input int b, input int p, input int o);
    @(posedge mclk);
    #1;
    sense_input_battery_side = b[17:0];
    sense_input_pack_side = p[17:0];
    input_offset_voltage = o[17:0];
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  initial
  begin
    repeat (95000) @(posedge mclk);
    mismatches++;
    close_out;
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    logic [15:0] v;
    int t;
    int dv;
    int n;
    repeat (3) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    rdc(`CDCC_ADDR_MODE, 8'h0e);
    rdc(`CDCC_ADDR_TMPCLR, 8'h60);
    host.wr(7'h00, 8'h5a);
    host.wr(`CDCC_ADDR_USER_LAST, 8'hc3);
    host.wr(`CDCC_ADDR_DIS_HI, 8'ha5);
    host.wr(`CDCC_ADDR_OFFSET, 8'h81);
    rdc(7'h00, 8'h5a);
    rdc(`CDCC_ADDR_USER_LAST, 8'hc3);
    rdc(`CDCC_ADDR_DIS_HI, 8'h00);
    rdc(`CDCC_ADDR_OFFSET, 8'h81);
    for (int c = 0; c < 8; c++)
    begin
      t = (c == 7) ? 549 : (c == 0) ? 0 : 3840 / c;
      host.wr(`CDCC_ADDR_MODE, {4'h0, c[2:0], 1'b0});
      for (int s = -1; s < 2; s += 2)
      begin
        drive(s * t, 0, 0);
        wait_cyc(2);
        check({15'h0, wake_oe}, 16'h0000);
        drive(s * (t + 1), 0, 0);
        wait_cyc(2);
        check({15'h0, wake_oe}, 16'h0001);
      end
    end
    check({15'h0, wake_out}, 16'h0000);
    host.wr(`CDCC_ADDR_MODE, 8'h0e);
    for (int k = 0; k < 2; k++)
    begin
      dv = k ? 51200 : -51200;
      drive(0, 0, 0);
      host.wr(`CDCC_ADDR_TMPCLR, 8'h1b);
      drive(0, -dv, 0);
      repeat (10 * TICK - 1) @(posedge mclk);
      drive(0, 0, 0);
      wait_cyc(2 * TICK);
      rd16c(`CDCC_ADDR_DTC_LO, k ? 16'h0000 : 16'h000a);
      rd16c(`CDCC_ADDR_DIS_LO, k ? 16'h0000 : 16'h000a);
      rd16c(`CDCC_ADDR_CTC_LO, k ? 16'h000a : 16'h0000);
      rd16c(`CDCC_ADDR_CHG_LO, k ? 16'h000a : 16'h0000);
    end
    wait_cyc(1);
    ce = 1'b0;
    drive(0, -51200, 0);
    wait_cyc(10 * TICK);
    drive(0, 0, 0);
    ce = 1'b1;
    rd16c(`CDCC_ADDR_CHG_LO, 16'h000a);
    host.wr(`CDCC_ADDR_TMPCLR, 8'h02);
    rdc(`CDCC_ADDR_TMPCLR, 8'h60);
    rd16c(`CDCC_ADDR_CHG_LO, 16'h0000);
    rd16c(`CDCC_ADDR_CTC_LO, 16'h000a);
    host.wr(`CDCC_ADDR_TMPCLR, 8'h10);
    rd16c(`CDCC_ADDR_CTC_LO, 16'h0000);
    rdc(`CDCC_ADDR_MODE, 8'h0e);
    host.wr(`CDCC_ADDR_MODE, 8'h02);
    drive(0, 3000, 0);
    host.wr(`CDCC_ADDR_TMPCLR, 8'h08);
    host.line(1'b0);
    repeat (LOWW - 10) @(posedge mclk);
    host.line(1'b1);
    host.line(1'b0);
    wait_cyc(LOWW - 10);
    check({15'h0, asleep}, 16'h0000);
    wait_cyc(15);
    check({15'h0, asleep}, 16'h0001);
    rd16(`CDCC_ADDR_DTC_LO, v);
    wait_cyc(10 * TICK);
    rd16c(`CDCC_ADDR_DTC_LO, v);
    host.line(1'b1);
    wait_cyc(2);
    check({15'h0, asleep}, 16'h0000);
    drive(0, 0, -100);
    temp_sensor_code = 3'h7;
    host.wr(`CDCC_ADDR_MODE, 8'h4e);
    host.wr(`CDCC_ADDR_TMPCLR, 8'h04);
    host.line(1'b0);
    wait_cyc(LOWW + 5);
    check({15'h0, cal_active}, 16'h0001);
    host.line(1'b1);
    wait_cyc(3);
    check({15'h0, cal_active}, 16'h0000);
    host.wr(`CDCC_ADDR_MODE, 8'hce);
    wait_cyc(3);
    check({15'h0, cal_active}, 16'h0001);
    drive(0, -1000, -100);
    wait_cyc(3);
    check({15'h0, cal_active}, 16'h0000);
    rdc(`CDCC_ADDR_MODE, 8'hce);
    drive(0, 0, -100);
    wait_cyc(5);
    n = 0;
    while (cal_active === 1'b1 && n < 90000)
    begin
      wait_cyc(1);
      n++;
    end
    #1;
    check({15'h0, n > 4096 * TICK - 40 && n < 4096 * TICK + 40}, 16'h0001);
    rdc(`CDCC_ADDR_OFFSET, 8'hf8);
    rdc(`CDCC_ADDR_MODE, 8'h0e);
    rd16(`CDCC_ADDR_SLC_LO, v);
    check({15'h0, v >= 16'h000f && v <= 16'h0011}, 16'h0001);
    rdc(`CDCC_ADDR_TMPCLR, 8'he0);
    close_out;
  end
endmodule // cdcc_core_test

`default_nettype wire
